// ===== src/tla_defines.vh
// register indices, field positions and reset values of the temperature limit alert block
`ifndef TLA_DEFINES_VH
`define TLA_DEFINES_VH
// register indices (byte address is four times the index)
`define TLA_IX_INT_TEMP   8'h00
`define TLA_IX_EXT_TEMP   8'h01
`define TLA_IX_STATUS     8'h02
`define TLA_IX_CONFIG     8'h03
`define TLA_IX_INT_HI     8'h05
`define TLA_IX_INT_LO     8'h06
`define TLA_IX_EXT_HI     8'h07
`define TLA_IX_EXT_LO     8'h08
`define TLA_IX_EXT_TLOW   8'h10
`define TLA_IX_EXT_THERM  8'h19
`define TLA_IX_CH_MASK    8'h1F
`define TLA_IX_INT_THERM  8'h20
`define TLA_IX_THERM_HYST 8'h21
`define TLA_IX_CONSEC     8'h22
`define TLA_IX_IDEALITY   8'h27
`define TLA_IX_INT_TLOW   8'h29
`define TLA_IX_FILTER     8'h40
// configuration bit positions
`define TLA_CFG_MASK      7
`define TLA_CFG_STANDBY   6
`define TLA_CFG_COMP      5
// consecutive register fields
`define TLA_CON_AL_LSB    1
`define TLA_CON_TH_LSB    4
// channel numbers
`define TLA_CH_INT        0
`define TLA_CH_EXT        1
// reset values
`define TLA_RST_CONFIG    8'h00
`define TLA_RST_HI_LIM    8'h55
`define TLA_RST_LO_LIM    8'h00
`define TLA_RST_TH_LIM    8'h55
`define TLA_RST_HYST      8'h0A
`define TLA_RST_CONSEC    8'h00
`define TLA_RST_IDEAL     6'h12
`define TLA_RST_FILTER    2'h0
`define TLA_RST_CH_MASK   2'h0
// filter settings
`define TLA_FILT_OFF      2'h0
`define TLA_FILT_L1       2'h1
`define TLA_FILT_L2       2'h2
`endif

// ===== src/tla_consec_qual.v
// consecutive measurement qualifier for one channel and one output pin
`timescale 1ns/1ps
module tla_consec_qual #(
   parameter CNT_W = 4,
   parameter CFG_W = 3
) (
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire             eval_i,
   input  wire             cond_i,
   input  wire [CFG_W-1:0] cfg_i,
   output wire             qual_o
);
   reg  [CNT_W-1:0] cnt_q;   // successive bad measurements, saturating
   reg  [CNT_W-1:0] cnt_d;   // next count
   wire [CNT_W-1:0] target;  // programmed count plus one

   assign target = {{(CNT_W-CFG_W){1'b0}}, cfg_i} + {{(CNT_W-1){1'b0}}, 1'b1};
   // qualified once the run of bad measurements reaches the target
   assign qual_o = (cnt_q >= target);

   // count bad measurements, restart on a good one
   always @*
   begin
      cnt_d = cnt_q;
      if (eval_i)
      begin
         if (!cond_i)
            cnt_d = {CNT_W{1'b0}};
         else if (cnt_q < target)
            cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // counter register
   always @(posedge clk_i)
   begin
      if (rst_i)
         cnt_q <= {CNT_W{1'b0}};
      else
         cnt_q <= cnt_d;
   end
endmodule

// ===== src/tla_alert_logic.v
// temperature limit alert and overtemperature logic with wishbone registers
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tla_defines.vh"
module tla_alert_logic #(
   parameter ADR_W  = 10,
   parameter TEMP_W = 11,
   parameter NCH    = 2
) (
   input  wire              clk_i,
   input  wire              rst_i,
   input  wire              wb_cyc_i,
   input  wire              wb_stb_i,
   input  wire              wb_we_i,
   input  wire [ADR_W-1:0]  wb_adr_i,
   input  wire [3:0]        wb_sel_i,
   input  wire [31:0]       wb_dat_i,
   output wire [31:0]       wb_dat_o,
   output wire              wb_ack_o,
   input  wire              meas_valid_i,
   input  wire              meas_chan_i,
   input  wire [TEMP_W-1:0] meas_temp_i,
   input  wire              meas_fault_i,
   input  wire              ara_done_i,
   output wire              standby_o,
   output wire [5:0]        ideality_o,
   output wire [1:0]        filter_sel_o,
   output wire              alert_n_o,
   output wire              alert_oe_o,
   output wire              overtemp_n_o,
   output wire              overtemp_oe_o
);
   // bus side state
   reg  [7:0]         cfg_q;        // block, standby and mode bits
   reg  [8*NCH-1:0]   hi_lim_q;     // high limits, byte per channel
   reg  [8*NCH-1:0]   lo_lim_q;     // low limits
   reg  [8*NCH-1:0]   th_lim_q;     // overtemperature limits
   reg  [7:0]         hyst_q;       // shared hysteresis
   reg  [7:0]         consec_q;     // consecutive counts
   reg  [5:0]         ideal_q;      // external ideality factor
   reg  [1:0]         filt_q;       // external filter setting
   reg  [NCH-1:0]     chmask_q;     // per-channel alert masks
   reg                ack_q;        // bus acknowledge
   reg  [7:0]         rdat_q;       // read data byte
   reg  [7:0]         rdat_d;       // read data mux
   reg                ot_q;         // overtemperature output state
   reg                cmp_q;        // comparator mode alert state
   reg                ot_d;         // next overtemperature state
   reg                cmp_d;        // next comparator state

   // channel side state
   wire [TEMP_W*NCH-1:0] temp_w;    // stored results
   wire [NCH-1:0]     hi_s;         // high status bits
   wire [NCH-1:0]     lo_s;         // low status bits
   wire [NCH-1:0]     th_s;         // overtemperature status bits
   wire [NCH-1:0]     flt_s;        // diode fault status bits
   wire [NCH-1:0]     al_set;       // qualified high for comparator
   wire [NCH-1:0]     ot_set;       // qualified overtemperature
   wire [NCH-1:0]     below_hi;     // below high limit minus hysteresis
   wire [NCH-1:0]     below_th;     // below overtemp limit minus hysteresis

   wire               req;          // bus request present
   wire [7:0]         idx;          // register index
   wire               wr_en;        // write takes effect this edge
   wire               rd_clr;       // status read completes this edge
   wire               eval;         // conversion result to evaluate
   wire               comp_mode;    // comparator mode selected
   wire               blocked;      // alert blocked in interrupt mode
   wire               int_alert;    // interrupt mode alert level

   // saturating subtract for hysteresis thresholds
   function [7:0] sat_sub;
      input [7:0] a;
      input [7:0] b;
      begin
         sat_sub = (a > b) ? (a - b) : 8'h00;
      end
   endfunction

   assign req       = wb_cyc_i & wb_stb_i;
   assign idx       = wb_adr_i[ADR_W-1:2];
   assign wr_en     = req & wb_we_i & ack_q & wb_sel_i[0];
   assign rd_clr    = req & ~wb_we_i & ack_q & (idx == `TLA_IX_STATUS);
   assign eval      = meas_valid_i & ~cfg_q[`TLA_CFG_STANDBY];
   assign comp_mode = cfg_q[`TLA_CFG_COMP];
   assign blocked   = cfg_q[`TLA_CFG_MASK];

   // per-channel measurement, qualification and status
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch = ch + 1)
      begin : g_ch
         wire        ev;      // conversion for this channel
         wire        flt;     // diode fault on this result
         wire [7:0]  hb;      // integer part of incoming result
         wire        hi_c;    // at or above high limit
         wire        lo_c;    // below low limit
         wire        th_c;    // at or above overtemp limit
         wire        alq;     // alert counter qualified
         wire        thq;     // overtemp counter qualified
         reg  [TEMP_W-1:0] temp_q;  // stored result
         reg         hi_l_q;  // last high condition
         reg         lo_l_q;  // last low condition
         reg         th_l_q;  // last overtemp condition
         reg         flt_l_q; // last fault condition
         reg         hi_s_q;  // high status
         reg         lo_s_q;  // low status
         reg         th_s_q;  // overtemp status
         reg         flt_s_q; // fault status

         assign ev   = eval & (meas_chan_i == ch);
         // only the external channel sees diode faults
         assign flt  = (ch == `TLA_CH_EXT) & meas_fault_i;
         assign hb   = meas_temp_i[TEMP_W-1:TEMP_W-8];
         assign hi_c = ~flt & (hb >= hi_lim_q[8*ch+7:8*ch]);
         // low check skipped on fault; a zero reading on the external channel counts as low
         assign lo_c = ~flt & ((hb < lo_lim_q[8*ch+7:8*ch]) |
                       ((ch == `TLA_CH_EXT) & (meas_temp_i == {TEMP_W{1'b0}})));
         assign th_c = ~flt & (hb >= th_lim_q[8*ch+7:8*ch]);

         // alert pin qualifier
         tla_consec_qual #(
            .CNT_W (4),
            .CFG_W (3)
         ) u_al (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .eval_i (ev),
            .cond_i (hi_c | lo_c | flt),
            .cfg_i  (consec_q[`TLA_CON_AL_LSB+2:`TLA_CON_AL_LSB]),
            .qual_o (alq)
         );

         // overtemperature pin qualifier
         tla_consec_qual #(
            .CNT_W (4),
            .CFG_W (3)
         ) u_th (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .eval_i (ev),
            .cond_i (th_c | flt),
            .cfg_i  (consec_q[`TLA_CON_TH_LSB+2:`TLA_CON_TH_LSB]),
            .qual_o (thq)
         );

         // store result and last conditions at each conversion
         always @(posedge clk_i)
         begin
            if (rst_i)
            begin
               temp_q  <= {TEMP_W{1'b0}};
               hi_l_q  <= 1'b0;
               lo_l_q  <= 1'b0;
               th_l_q  <= 1'b0;
               flt_l_q <= 1'b0;
            end
            else if (ev)
            begin
               // fault reports zero; a grounded negative pin is a normal result
               temp_q  <= flt ? {TEMP_W{1'b0}} : meas_temp_i;
               hi_l_q  <= hi_c;
               lo_l_q  <= lo_c;
               th_l_q  <= th_c | flt;
               flt_l_q <= flt;
            end
         end

         // status bits: sticky in interrupt mode, set beats clear
         always @(posedge clk_i)
         begin
            if (rst_i)
            begin
               hi_s_q  <= 1'b0;
               lo_s_q  <= 1'b0;
               th_s_q  <= 1'b0;
               flt_s_q <= 1'b0;
            end
            else
            begin
               if (comp_mode)
                  hi_s_q <= cmp_d ? (hi_s_q | al_set[ch]) : 1'b0;
               else
                  hi_s_q <= (alq & hi_l_q) | (hi_s_q & ~rd_clr);
               lo_s_q  <= (alq & lo_l_q) | (lo_s_q & ~rd_clr);
               flt_s_q <= (alq & flt_l_q) | (flt_s_q & ~rd_clr);
               // overtemp status not cleared by reads, only on release
               th_s_q  <= ot_d ? (th_s_q | ot_set[ch]) : 1'b0;
            end
         end

         assign temp_w[TEMP_W*ch+TEMP_W-1:TEMP_W*ch] = temp_q;
         assign hi_s[ch]     = hi_s_q;
         assign lo_s[ch]     = lo_s_q;
         assign th_s[ch]     = th_s_q;
         assign flt_s[ch]    = flt_s_q;
         assign al_set[ch]   = alq & hi_l_q & ~chmask_q[ch];
         assign ot_set[ch]   = thq & th_l_q;
         assign below_hi[ch] = temp_q[TEMP_W-1:TEMP_W-8] <
                               sat_sub(hi_lim_q[8*ch+7:8*ch], hyst_q);
         assign below_th[ch] = temp_q[TEMP_W-1:TEMP_W-8] <
                               sat_sub(th_lim_q[8*ch+7:8*ch], hyst_q);
      end
   endgenerate

   // next pin states with hysteresis release
   always @*
   begin
      ot_d = ot_q;
      if (|ot_set)
         ot_d = 1'b1;
      else if (&below_th)
         ot_d = 1'b0;
      cmp_d = cmp_q;
      if (!comp_mode)
         cmp_d = 1'b0;
      else if (|al_set)
         cmp_d = 1'b1;
      else if (&below_hi)
         cmp_d = 1'b0;
   end

   // pin state registers
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ot_q  <= 1'b0;
         cmp_q <= 1'b0;
      end
      else
      begin
         ot_q  <= ot_d;
         cmp_q <= cmp_d;
      end
   end

   // interrupt mode: any unmasked high, low or fault status bit holds the alert unless blocked
   assign int_alert = ~blocked & |((hi_s | lo_s | flt_s) & ~chmask_q);

   // open-drain pins only ever pull low
   assign alert_n_o     = 1'b0;
   assign alert_oe_o    = comp_mode ? cmp_q : int_alert;
   assign overtemp_n_o  = 1'b0;
   assign overtemp_oe_o = ot_q;

   assign standby_o    = cfg_q[`TLA_CFG_STANDBY];
   assign ideality_o   = ideal_q;
   assign filter_sel_o = filt_q;

   // configuration and limit registers
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_q    <= `TLA_RST_CONFIG;
         hi_lim_q <= {NCH{`TLA_RST_HI_LIM}};
         lo_lim_q <= {NCH{`TLA_RST_LO_LIM}};
         th_lim_q <= {NCH{`TLA_RST_TH_LIM}};
         hyst_q   <= `TLA_RST_HYST;
         consec_q <= `TLA_RST_CONSEC;
         ideal_q  <= `TLA_RST_IDEAL;
         filt_q   <= `TLA_RST_FILTER;
         chmask_q <= `TLA_RST_CH_MASK;
      end
      else
      begin
         if (wr_en)
         begin
            case (idx)
               `TLA_IX_CONFIG:     cfg_q <= wb_dat_i[7:0];
               `TLA_IX_INT_HI:     hi_lim_q[7:0] <= wb_dat_i[7:0];
               `TLA_IX_INT_LO:     lo_lim_q[7:0] <= wb_dat_i[7:0];
               `TLA_IX_EXT_HI:     hi_lim_q[15:8] <= wb_dat_i[7:0];
               `TLA_IX_EXT_LO:     lo_lim_q[15:8] <= wb_dat_i[7:0];
               `TLA_IX_INT_THERM:  th_lim_q[7:0] <= wb_dat_i[7:0];
               `TLA_IX_EXT_THERM:  th_lim_q[15:8] <= wb_dat_i[7:0];
               `TLA_IX_THERM_HYST: hyst_q <= wb_dat_i[7:0];
               `TLA_IX_CONSEC:     consec_q <= wb_dat_i[7:0];
               `TLA_IX_IDEALITY:   ideal_q <= wb_dat_i[5:0];
               `TLA_IX_CH_MASK:    chmask_q <= wb_dat_i[NCH-1:0];
               // three settings only; the spare code selects off
               `TLA_IX_FILTER:     filt_q <= (wb_dat_i[1:0] == `TLA_FILT_L1 ||
                                              wb_dat_i[1:0] == `TLA_FILT_L2) ?
                                             wb_dat_i[1:0] : `TLA_FILT_OFF;
               default:            cfg_q <= cfg_q;
            endcase
         end
         // alert response wins over a software write of the same edge
         if (ara_done_i)
            cfg_q[`TLA_CFG_MASK] <= 1'b1;
      end
   end

   // read data mux, unmapped reads return zero
   always @*
   begin
      case (idx)
         `TLA_IX_INT_TEMP:   rdat_d = temp_w[TEMP_W-1:TEMP_W-8];
         `TLA_IX_EXT_TEMP:   rdat_d = temp_w[2*TEMP_W-1:2*TEMP_W-8];
         `TLA_IX_INT_TLOW:   rdat_d = {temp_w[2:0], 5'h00};
         `TLA_IX_EXT_TLOW:   rdat_d = {temp_w[TEMP_W+2:TEMP_W], 5'h00};
         `TLA_IX_STATUS:     rdat_d = {1'b0, flt_s[`TLA_CH_EXT], th_s[1], lo_s[1], hi_s[1],
                                       th_s[0], lo_s[0], hi_s[0]};
         `TLA_IX_CONFIG:     rdat_d = cfg_q;
         `TLA_IX_INT_HI:     rdat_d = hi_lim_q[7:0];
         `TLA_IX_INT_LO:     rdat_d = lo_lim_q[7:0];
         `TLA_IX_EXT_HI:     rdat_d = hi_lim_q[15:8];
         `TLA_IX_EXT_LO:     rdat_d = lo_lim_q[15:8];
         `TLA_IX_INT_THERM:  rdat_d = th_lim_q[7:0];
         `TLA_IX_EXT_THERM:  rdat_d = th_lim_q[15:8];
         `TLA_IX_THERM_HYST: rdat_d = hyst_q;
         `TLA_IX_CONSEC:     rdat_d = consec_q;
         `TLA_IX_IDEALITY:   rdat_d = {2'h0, ideal_q};
         `TLA_IX_CH_MASK:    rdat_d = {6'h00, chmask_q};
         `TLA_IX_FILTER:     rdat_d = {6'h00, filt_q};
         default:            rdat_d = 8'h00;
      endcase
   end

   // one wait state: ack one cycle after the request, then drop
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q  <= 1'b0;
         rdat_q <= 8'h00;
      end
      else
      begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q)
            rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = {24'h000000, rdat_q};
endmodule

// ===== bench/tla_alert_assertions.sv
// port assertions for the temperature limit alert block
`timescale 1ns/1ps
`include "tla_defines.vh"
module tla_alert_assertions #(
   parameter ADR_W = 10
) (
   input wire             clk_i,
   input wire             rst_i,
   input wire             wb_cyc_i,
   input wire             wb_stb_i,
   input wire             wb_we_i,
   input wire [ADR_W-1:0] wb_adr_i,
   input wire [3:0]       wb_sel_i,
   input wire [31:0]      wb_dat_i,
   input wire [31:0]      wb_dat_o,
   input wire             wb_ack_o,
   input wire             meas_valid_i,
   input wire             ara_done_i,
   input wire             standby_o,
   input wire [5:0]       ideality_o,
   input wire [1:0]       filter_sel_o,
   input wire             alert_n_o,
   input wire             alert_oe_o,
   input wire             overtemp_n_o,
   input wire             overtemp_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire [7:0] ix_w = wb_adr_i[9:2];                  // register index
   wire       wr_w = wb_ack_o & wb_we_i & wb_sel_i[0]; // write taking effect
   wire       cw_w = wr_w && ix_w == `TLA_IX_CONFIG;   // config write
   reg  [7:0] cfg_q;                                  // shadow of config
   // shadow follows config writes; alert response sets the block bit
   always @(posedge clk_i)
   begin
      if (rst_i)
         cfg_q <= 8'h00;
      else if (ara_done_i)
         cfg_q <= {1'b1, cw_w ? wb_dat_i[6:0] : cfg_q[6:0]};
      else if (cw_w)
         cfg_q <= wb_dat_i[7:0];
   end
   a_alert_drain: assert property (alert_n_o == 1'b0)
      else $error("alert pin driven high");
   a_ot_drain: assert property (overtemp_n_o == 1'b0)
      else $error("overtemp pin driven high");
   a_ack_next: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_dat_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_ot_cause: assert property ($rose(overtemp_oe_o) |-> $past(meas_valid_i, 2) && !$past(standby_o, 2))
      else $error("overtemp rose without a measurement");
   a_block_quiet: assert property (cfg_q[7] && !cfg_q[5] |-> !alert_oe_o)
      else $error("blocked alert still active");
   a_ara_block: assert property (ara_done_i && !cfg_q[5] |=> !alert_oe_o)
      else $error("alert response did not release alert");
   a_standby_cfg: assert property (standby_o == cfg_q[6])
      else $error("standby differs from config");
   a_ideal_write: assert property (wr_w && ix_w == `TLA_IX_IDEALITY |=> ideality_o == $past(wb_dat_i[5:0]))
      else $error("ideality not updated");
   a_filter_write: assert property (wr_w && ix_w == `TLA_IX_FILTER |=>
      filter_sel_o == ($past(wb_dat_i[1:0]) == 2'h3 ? 2'h0 : $past(wb_dat_i[1:0])))
      else $error("filter select not updated");
   // main scenarios reached
   c_ot_rise: cover property ($rose(overtemp_oe_o));
   c_alert_rise: cover property ($rose(alert_oe_o));
   c_ara: cover property (ara_done_i ##1 !alert_oe_o);
endmodule

// ===== bench/tla_meas_src.sv
// conversion front end model feeding results and alert responses
`timescale 1ns/1ps
module tla_meas_src (
   input  wire clk_i,
   output reg  meas_valid_o,
   output reg  meas_chan_o,
   output reg  [10:0] meas_temp_o,
   output reg  meas_fault_o,
   output reg  ara_done_o
);
   // idle lines at time zero
   initial
   begin
      meas_valid_o = 1'b0;
      meas_chan_o = 1'b0;
      meas_temp_o = 11'h000;
      meas_fault_o = 1'b0;
      ara_done_o = 1'b0;
   end
   // one result pulse; a faulted or shorted diode reads zero
   task convert(input logic ch, input logic [7:0] t, input logic f);
   begin
      @(posedge clk_i);
      meas_valid_o <= 1'b1;
      meas_chan_o <= ch;
      meas_temp_o <= f ? 11'h000 : {t, 3'h0};
      meas_fault_o <= f;
      @(posedge clk_i);
      meas_valid_o <= 1'b0;
      meas_chan_o <= ~ch; // released lines do not keep their value
      meas_temp_o <= ~meas_temp_o;
      meas_fault_o <= ~f;
      @(posedge clk_i);
   end
   endtask
   // full alert response address answered
   task ara;
   begin
      @(posedge clk_i);
      ara_done_o <= 1'b1;
      @(posedge clk_i);
      ara_done_o <= 1'b0;
   end
   endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the temperature limit alert block
`timescale 1ns/1ps
module tb_top;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         wb_cyc_i = 1'b0;
   reg         wb_stb_i = 1'b0;
   reg         wb_we_i = 1'b0;
   reg  [9:0]  wb_adr_i = 10'h000;
   reg  [3:0]  wb_sel_i = 4'h0;
   reg  [31:0] wb_dat_i = 32'h00000000;
   wire [31:0] wb_dat_o;
   wire        wb_ack_o, meas_valid_i, meas_chan_i, meas_fault_i, ara_done_i;
   wire [10:0] meas_temp_i;
   wire        standby_o, alert_n_o, alert_oe_o, overtemp_n_o, overtemp_oe_o;
   wire [5:0]  ideality_o;
   wire [1:0]  filter_sel_o;
   integer     err_count = 0;
   integer     samples_checked = 0;
   reg  [31:0] rd;   // last read data
   integer     i;
   // register index and reset value table, unmapped 3F in entry 0 and read first
   localparam [103:0] RIX = {8'h03,8'h05,8'h06,8'h07,8'h08,8'h19,8'h1F,8'h20,8'h21,8'h22,8'h27,8'h40,8'h3F};
   localparam [103:0] RVL = {8'h00,8'h55,8'h00,8'h55,8'h00,8'h55,8'h00,8'h55,8'h0A,8'h00,8'h12,8'h00,8'h00};
   always #25 clk_i = ~clk_i;
   tla_alert_logic u_tla_alert_logic (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .meas_valid_i, .meas_chan_i, .meas_temp_i, .meas_fault_i, .ara_done_i,
      .standby_o, .ideality_o, .filter_sel_o, .alert_n_o, .alert_oe_o, .overtemp_n_o, .overtemp_oe_o);
   tla_meas_src u_tla_meas_src (.clk_i, .meas_valid_o(meas_valid_i), .meas_chan_o(meas_chan_i),
      .meas_temp_o(meas_temp_i), .meas_fault_o(meas_fault_i), .ara_done_o(ara_done_i));
   // compare and count
   task chk(input [31:0] got, input [31:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask
   // one classic wishbone cycle, held until ack
   task wb(input w, input [7:0] ix, input [7:0] d);
      integer n;
   begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {ix, 2'b00};
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h000000, d};
      n = 0;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
         n = n + 1;
         @(posedge clk_i);
      end
      if (n == 20)
      begin
         err_count = err_count + 1;
         $display("ERROR %0t no bus acknowledge", $time);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   end
   endtask
   task wr(input [7:0] ix, input [7:0] d);
      wb(1'b1, ix, d);
   endtask
   // read and compare
   task rdc(input [7:0] ix, input [7:0] e);
   begin
      wb(1'b0, ix, 8'h00);
      chk(rd, {24'h000000, e});
   end
   endtask
   task cv(input c, input [7:0] t, input f);
      u_tla_meas_src.convert(c, t, f);
   endtask
   // verdict and end of run
   task report_and_stop;
   begin
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   // hang guard
   initial
   begin
      #(50 * 5000);
      err_count = err_count + 1;
      report_and_stop;
   end
   // main sequence
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({ideality_o, filter_sel_o, standby_o, alert_oe_o, overtemp_oe_o}, {6'h12, 5'h00});
      wr(8'h3F, 8'hFF);
      for (i = 0; i < 13; i = i + 1)
         rdc(RIX[i*8 +: 8], RVL[i*8 +: 8]);
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(8'h40, i[7:0]);
         #1 chk(filter_sel_o, (i == 3) ? 2'h0 : i[1:0]);
      end
      wr(8'h27, 8'h3F);
      #1 chk(ideality_o, 6'h3F);
      // interrupt mode: high limit, sticky status, read clear
      wr(8'h07, 8'h40);
      cv(1, 8'h40, 0);
      #1 chk(alert_oe_o, 1'b1);
      cv(1, 8'h30, 0);
      #1 chk(alert_oe_o, 1'b1);
      rdc(8'h02, 8'h08);
      #1 chk(alert_oe_o, 1'b0);
      rdc(8'h02, 8'h00);
      // blocked output, status still updates
      wr(8'h06, 8'h10);
      wr(8'h03, 8'h80);
      cv(0, 8'h05, 0);
      #1 chk(alert_oe_o, 1'b0);
      rdc(8'h02, 8'h02);
      wr(8'h03, 8'h00);
      cv(0, 8'h05, 0);
      #1 chk(alert_oe_o, 1'b1);
      rdc(8'h02, 8'h02);
      // in-limit internal reading, then the read clears the sticky low bit
      cv(0, 8'h20, 0);
      rdc(8'h02, 8'h02);
      // diode fault, then shorted diode, then grounded negative pin
      cv(1, 8'h50, 1);
      #1 chk(overtemp_oe_o, 1'b1);
      rdc(8'h01, 8'h00);
      rdc(8'h02, 8'h60);
      cv(1, 8'h00, 0);
      #1 chk(overtemp_oe_o, 1'b0);
      rdc(8'h02, 8'h50);
      cv(1, 8'h30, 0);
      rdc(8'h02, 8'h10);
      #1 chk(alert_oe_o, 1'b0);
      // overtemp needs three in a row; a cool reading restarts
      wr(8'h22, 8'h20);
      for (i = 0; i < 6; i = i + 1)
      begin
         cv(0, (i == 2) ? 8'h20 : 8'h60, 0);
         #1 chk(overtemp_oe_o, i == 5);
      end
      rdc(8'h02, 8'h05);
      rdc(8'h02, 8'h05);
      wr(8'h03, 8'h80);
      wr(8'h1F, 8'h03);
      #1 chk(overtemp_oe_o, 1'b1);
      cv(0, 8'h50, 0);
      #1 chk(overtemp_oe_o, 1'b1);
      cv(0, 8'h4A, 0);
      #1 chk(overtemp_oe_o, 1'b0);
      rdc(8'h02, 8'h01);
      wr(8'h03, 8'h00);
      wr(8'h1F, 8'h00);
      wr(8'h22, 8'h00);
      // comparator mode with hysteresis, block ignored, channel mask
      wr(8'h05, 8'h40);
      wr(8'h03, 8'h20);
      cv(0, 8'h40, 0);
      #1 chk(alert_oe_o, 1'b1);
      rdc(8'h02, 8'h01);
      rdc(8'h02, 8'h01);
      wr(8'h03, 8'hA0);
      #1 chk(alert_oe_o, 1'b1);
      cv(0, 8'h3A, 0);
      #1 chk(alert_oe_o, 1'b1);
      cv(0, 8'h35, 0);
      #1 chk(alert_oe_o, 1'b0);
      rdc(8'h02, 8'h00);
      wr(8'h1F, 8'h01);
      cv(0, 8'h45, 0);
      #1 chk(alert_oe_o, 1'b0);
      // alert response releases the pin until unblocked
      wr(8'h1F, 8'h00);
      wr(8'h03, 8'h00);
      cv(0, 8'h05, 0);
      #1 chk(alert_oe_o, 1'b1);
      u_tla_meas_src.ara;
      #1 chk(alert_oe_o, 1'b0);
      rdc(8'h03, 8'h80);
      wr(8'h03, 8'h00);
      #1 chk(alert_oe_o, 1'b1);
      // standby ignores conversions
      wr(8'h03, 8'h40);
      #1 chk(standby_o, 1'b1);
      cv(0, 8'h70, 0);
      rdc(8'h00, 8'h05);
      #1 chk(overtemp_oe_o, 1'b0);
      wr(8'h03, 8'h00);
      report_and_stop;
   end
endmodule
bind tla_alert_logic tla_alert_assertions #(.ADR_W(ADR_W)) u_tla_alert_assertions (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .meas_valid_i, .ara_done_i,
   .standby_o, .ideality_o, .filter_sel_o, .alert_n_o, .alert_oe_o, .overtemp_n_o, .overtemp_oe_o);
